// File: tx_line_pkg.sv
// Purpose: shared types and constants of the transmit line encoder
// Assumes: one 200 MHz system clock; framer pins arrive asynchronously
// Notes: control bits are plain ports, no register bus
// Behaviour
// (RULE_01) single-rail: NRZ on positive rail, negative grounded
// (RULE_02) pin high or bit 0 one selects single-rail
// (RULE_03) dual-rail: framer drives marks on matching rails
// (RULE_04) pin low or bit 0 zero selects dual-rail
// (RULE_05) framer clock runs at selected line rate
// (RULE_06) single-rail encodes B3ZS for DS3/STS-1, HDB3 for E3
// (RULE_07) three zeros become B0V or 00V
// (RULE_08) B3ZS keeps odd marks between violations
// (RULE_09) four zeros become 000V or B00V
// (RULE_10) HDB3 keeps odd marks between violations
// (RULE_11) dual-rail bypasses the zero-substitution encoder
// (RULE_12) dual-rail violations become alternating marks
// (RULE_13) encoder and receive decoder active only single-rail
// (RULE_14) build-out off when select high, on when low
// (RULE_15) E3 always keeps build-out disabled
// (RULE_16) host mode uses control bits, hardware mode pins
package tx_line_pkg;

  typedef enum logic [1:0] {
    LINE_E3 = 2'h0,
    LINE_DS3 = 2'h1,
    LINE_STS1 = 2'h3
  } line_mode_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_t;

  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PIPE_DEPTH = 4;
  localparam logic [2:0] B3ZS_RUN = 3'h3;
  localparam logic [2:0] HDB3_RUN = 3'h4;
  localparam rail_pair_t SYM_SPACE = 2'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic POL_RST = 1'h0;

endpackage : tx_line_pkg

// File: tx_line_encoder.sv
// Purpose: framer rail capture, B3ZS/HDB3 zero substitution, build-out select
// Assumes: framer clock well below half of clk_i, so edges are seen on samples
// Notes: fixed latency of four symbols through the substitution window
`timescale 1ns/1ps

// plain synchronous FIFO; the encoder drains it when the output register is empty or the line takes data
module rail_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // extra pointer bit tells full from empty
  assign out_valid_o = (wr_q != rd_q);
  assign in_ready_o = ~((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule : rail_fifo

module tx_line_encoder (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tx_line_clock_i,
  input wire logic pos_rail_tx_in_i,
  input wire logic neg_rail_tx_in_i,
  input wire logic rail_format_select_i,
  input wire logic build_out_select_i,
  input wire logic host_mode_i,
  input wire logic ctrl_rail_format_i,
  input wire logic ctrl_build_out_i,
  input wire tx_line_pkg::line_mode_t line_mode_i,
  output logic sample_ready_o,
  output logic sample_overrun_o,
  output tx_line_pkg::rail_pair_t line_sym_o,
  output logic line_valid_o,
  input wire logic line_ready_i,
  output logic single_rail_o,
  output logic decoder_enable_o,
  output logic build_out_en_o
);
  import tx_line_pkg::*;

  // pulse pattern for a mark of the given polarity
  function automatic rail_pair_t pol_sym(input logic pol);
    pol_sym = pol ? 2'h2 : 2'h1;
  endfunction : pol_sym

  // two-stage synchronisers; stage 0 feeds only stage 1
  logic [4:0] sync0_q;
  logic [4:0] sync1_q;
  logic clk_seen_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync0_q <= '0;
      sync1_q <= '0;
      clk_seen_q <= 1'h0;
    end
    else
    begin
      sync0_q <= {build_out_select_i, rail_format_select_i, neg_rail_tx_in_i,
                  pos_rail_tx_in_i, tx_line_clock_i};
      sync1_q <= sync0_q;
      clk_seen_q <= sync1_q[0];
    end
  end

  // data is taken on the framer clock falling edge
  wire fall_edge = clk_seen_q & ~sync1_q[0];
  wire rail_pair_t cap_sym = {sync1_q[1], sync1_q[2]};
  wire rail_pin_s = sync1_q[3];
  wire bo_pin_s = sync1_q[4];

  // configuration source selection
  wire single_d = host_mode_i ? ctrl_rail_format_i : rail_pin_s; // RULE_16 RULE_02 RULE_04
  wire bo_sel = host_mode_i ? ctrl_build_out_i : bo_pin_s; // RULE_16
  wire is_e3 = (line_mode_i == LINE_E3);
  wire bo_en_d = ~bo_sel & ~is_e3; // RULE_14 RULE_15
  wire [2:0] run_len = is_e3 ? HDB3_RUN : B3ZS_RUN; // RULE_06
  logic [2:0] cfg_q;
  wire [2:0] cfg_d = {single_d, line_mode_i};
  wire flush = (cfg_d != cfg_q);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_q <= '0;
      single_rail_o <= 1'h0;
      decoder_enable_o <= 1'h0;
      build_out_en_o <= 1'h0;
    end
    else
    begin
      cfg_q <= cfg_d;
      single_rail_o <= single_d;
      decoder_enable_o <= single_d; // RULE_13
      build_out_en_o <= bo_en_d;
    end
  end

  // elastic store between framer samples and line output
  rail_pair_t fifo_sym;
  logic fifo_valid;
  wire out_space = ~line_valid_o | line_ready_i;
  wire step = fifo_valid & out_space & ~flush;
  rail_fifo #(
    .WIDTH(2),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(cap_sym),
    .in_valid_i(fall_edge),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_sym),
    .out_valid_o(fifo_valid),
    .out_ready_i(step)
  );
  assign sample_overrun_o = fall_edge & ~sample_ready_o;

  // entry decision: marks alternate, zero runs get substituted
  logic pol_q;
  logic par_q;
  logic [2:0] zcnt_q;
  wire in_mark = single_rail_o ? fifo_sym.pos : (fifo_sym.pos | fifo_sym.neg); // RULE_01 RULE_12
  wire hit = single_rail_o & ~in_mark & (zcnt_q == run_len - 3'h1); // RULE_07 RULE_09 RULE_11
  wire use_b = hit & ~par_q; // RULE_08 RULE_10
  wire pol_d = (in_mark | use_b) ? ~pol_q : pol_q;
  wire rail_pair_t in_sym = (in_mark | hit) ? pol_sym(pol_d) : SYM_SPACE;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | flush)
    begin
      pol_q <= POL_RST;
      par_q <= 1'h0;
      zcnt_q <= '0;
    end
    else if (step)
    begin
      pol_q <= pol_d;
      par_q <= hit ? 1'h0 : (par_q ^ in_mark); // RULE_08 RULE_10
      zcnt_q <= (in_mark | hit) ? 3'h0 : zcnt_q + 3'h1;
    end
  end

  // substitution window; the B of B0V/B00V lands on the oldest zero
  rail_pair_t sym_q [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] vld_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | flush)
    begin
      vld_q <= '0;
      sym_q[0] <= SYM_SPACE;
    end
    else if (step)
    begin
      vld_q <= {vld_q[PIPE_DEPTH-2:0], 1'h1};
      sym_q[0] <= in_sym;
    end
  end

  for (genvar i = 1; i < PIPE_DEPTH; i++)
  begin : g_slot
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i | flush)
      begin
        sym_q[i] <= SYM_SPACE;
      end
      else if (step)
      begin
        sym_q[i] <= (use_b && (3'(i) == run_len - 3'h1)) ? pol_sym(pol_d) : sym_q[i-1]; // RULE_07 RULE_09
      end
    end
  end

  // line output register; holds until the shaper takes it
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      line_sym_o <= SYM_SPACE;
      line_valid_o <= 1'h0;
    end
    else if (step)
    begin
      line_sym_o <= sym_q[PIPE_DEPTH-1];
      line_valid_o <= vld_q[PIPE_DEPTH-1];
    end
    else if (line_ready_i)
    begin
      line_valid_o <= 1'h0;
    end
  end

  // helper state watching accepted line symbols
  wire fire = line_valid_o & line_ready_i;
  wire out_mark = line_sym_o.pos | line_sym_o.neg;
  logic chk_pol_q;
  logic chk_seen_q;
  logic chk_vseen_q;
  logic chk_par_q;
  logic [2:0] chk_zero_q;
  wire is_v = fire & out_mark & chk_seen_q & (line_sym_o.pos == chk_pol_q);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i | flush)
    begin
      chk_pol_q <= 1'h0;
      chk_seen_q <= 1'h0;
      chk_vseen_q <= 1'h0;
      chk_par_q <= 1'h0;
      chk_zero_q <= '0;
    end
    else if (fire)
    begin
      chk_zero_q <= out_mark ? 3'h0 : chk_zero_q + 3'h1;
      if (out_mark)
      begin
        chk_pol_q <= line_sym_o.pos;
        chk_seen_q <= 1'h1;
        chk_vseen_q <= chk_vseen_q | is_v;
        chk_par_q <= is_v ? 1'h0 : ~chk_par_q;
      end
    end
  end

  property p_rail_sel;
    @(posedge clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> single_rail_o == $past(single_d);
  endproperty
  a_rail_sel: assert property (p_rail_sel) else $error("rail format not followed"); // RULE_02

  property p_dual_bypass;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!host_mode_i && !rail_pin_s) ##1 1 |-> !single_rail_o && !decoder_enable_o;
  endproperty
  a_dual_bypass: assert property (p_dual_bypass) else $error("dual-rail pin ignored"); // RULE_04

  property p_host_bit;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && host_mode_i && $stable(host_mode_i)) |=> single_rail_o == $past(ctrl_rail_format_i);
  endproperty
  a_host_bit: assert property (p_host_bit) else $error("host bit not used"); // RULE_16

  property p_build_out;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !is_e3) |=> build_out_en_o == !$past(bo_sel);
  endproperty
  a_build_out: assert property (p_build_out) else $error("build-out select wrong"); // RULE_14

  property p_e3_no_bo;
    @(posedge clk_i) disable iff (sys_rst_i)
    is_e3 |=> !build_out_en_o;
  endproperty
  a_e3_no_bo: assert property (p_e3_no_bo) else $error("build-out on in E3"); // RULE_15

  property p_b3zs_run;
    @(posedge clk_i) disable iff (sys_rst_i)
    (single_rail_o && !is_e3) |-> chk_zero_q < B3ZS_RUN;
  endproperty
  a_b3zs_run: assert property (p_b3zs_run) else $error("three zeros sent"); // RULE_07

  property p_hdb3_run;
    @(posedge clk_i) disable iff (sys_rst_i)
    (single_rail_o && is_e3) |-> chk_zero_q < HDB3_RUN;
  endproperty
  a_hdb3_run: assert property (p_hdb3_run) else $error("four zeros sent"); // RULE_09

  property p_b3zs_odd;
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_v && chk_vseen_q && !is_e3) |-> chk_par_q;
  endproperty
  a_b3zs_odd: assert property (p_b3zs_odd) else $error("even marks between V"); // RULE_08

  property p_hdb3_odd;
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_v && chk_vseen_q && is_e3) |-> chk_par_q;
  endproperty
  a_hdb3_odd: assert property (p_hdb3_odd) else $error("even marks between V"); // RULE_10

  property p_dual_ami;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!single_rail_o && $stable(cfg_q)) |-> !is_v;
  endproperty
  a_dual_ami: assert property (p_dual_ami) else $error("violation in dual-rail"); // RULE_12

  property p_one_rail;
    @(posedge clk_i) disable iff (sys_rst_i)
    line_valid_o |-> !(line_sym_o.pos && line_sym_o.neg);
  endproperty
  a_one_rail: assert property (p_one_rail) else $error("both rails driven"); // RULE_11

  property p_dec_en;
    @(posedge clk_i) disable iff (sys_rst_i)
    decoder_enable_o == single_rail_o;
  endproperty
  a_dec_en: assert property (p_dec_en) else $error("decoder enable wrong"); // RULE_13

  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && line_valid_o && !line_ready_i) |=> line_valid_o && $stable(line_sym_o);
  endproperty
  a_hold: assert property (p_hold) else $error("symbol dropped"); // RULE_06

endmodule : tx_line_encoder

// File: framer_model.sv
// Purpose: behavioural framer that feeds rail samples to the encoder
// Assumes: one sample per 8 clk_i cycles, well inside the sync limits
// Notes: the framer clock stands low between samples
`timescale 1ns/1ps
module framer_model (
  input wire logic clk_i,
  output logic line_clk_o,
  output logic pos_o,
  output logic neg_o
);
  initial
  begin
    line_clk_o = 1'b0;
    pos_o = 1'b0;
    neg_o = 1'b0;
  end

  // data settles with the clock high and is held past the fall
  task automatic send(input logic p, input logic n);
    @(posedge clk_i);
    pos_o <= p;
    neg_o <= n;
    line_clk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    line_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    pos_o <= ~p; // hold has expired, so the old value must not linger
  endtask : send
endmodule : framer_model

// File: tb.sv
// Purpose: self-checking bench for the transmit line encoder
// Assumes: framer model gives one sample per 8 clk_i cycles
// Notes: streams are padded with marks so the window drains
`timescale 1ns/1ps
module tb;
  import tx_line_pkg::*;
  typedef struct packed {
    logic host;
    logic crf;
    logic cbo;
    logic prf;
    logic pbo;
    line_mode_t mode;
    logic sr;
    logic bo;
  } cfg_row_t;
  localparam rail_pair_t MARK_P = 2'h2;
  localparam rail_pair_t MARK_N = 2'h1;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tx_clk, pos_rail, neg_rail;
  logic rail_format_select_i = 1'b0, build_out_select_i = 1'b0, host_mode_i = 1'b0;
  logic ctrl_rail_format_i = 1'b0, ctrl_build_out_i = 1'b0, line_ready_i = 1'b1;
  line_mode_t line_mode_i = LINE_DS3;
  logic sample_ready_o, sample_overrun_o, line_valid_o;
  logic single_rail_o, decoder_enable_o, build_out_en_o;
  rail_pair_t line_sym_o;
  rail_pair_t in_q[$], exp_q[$], got_q[$];
  int error_cnt = 0, num_checks = 0, cycles = 0;
  logic ovr_seen = 1'b0, full_seen = 1'b0;
  cfg_row_t rows[8];

  always #2.5 clk_i = ~clk_i;

  framer_model i_framer (.clk_i(clk_i), .line_clk_o(tx_clk), .pos_o(pos_rail), .neg_o(neg_rail));

  tx_line_encoder i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_line_clock_i(tx_clk),
    .pos_rail_tx_in_i(pos_rail), .neg_rail_tx_in_i(neg_rail),
    .rail_format_select_i(rail_format_select_i), .build_out_select_i(build_out_select_i),
    .host_mode_i(host_mode_i), .ctrl_rail_format_i(ctrl_rail_format_i),
    .ctrl_build_out_i(ctrl_build_out_i), .line_mode_i(line_mode_i),
    .sample_ready_o(sample_ready_o), .sample_overrun_o(sample_overrun_o),
    .line_sym_o(line_sym_o), .line_valid_o(line_valid_o), .line_ready_i(line_ready_i),
    .single_rail_o(single_rail_o), .decoder_enable_o(decoder_enable_o),
    .build_out_en_o(build_out_en_o)
  );

  // monitor: collects taken symbols, flags overflow, cuts a hang short
  always @(posedge clk_i)
  begin
    cycles++;
    if (sample_overrun_o === 1'b1) ovr_seen = 1'b1;
    if (sample_ready_o === 1'b0) full_seen = 1'b1;
    if (line_valid_o === 1'b1 && line_ready_i === 1'b1) got_q.push_back(line_sym_o);
    if (cycles == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // host-mode setup and a fresh reset, so parity and polarity start known
  task automatic setup(input logic sr, input line_mode_t m);
    @(posedge clk_i);
    host_mode_i <= 1'b1;
    ctrl_rail_format_i <= sr;
    ctrl_build_out_i <= 1'b0;
    line_mode_i <= m;
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    got_q.delete();
  endtask : setup

  task automatic load(input logic [31:0] p, input logic [31:0] n, input int cnt);
    in_q.delete();
    for (int i = cnt - 1; i >= 0; i--) in_q.push_back({p[i], n[i]});
  endtask : load

  // reference coder; run 0 means plain alternation with no substitution
  task automatic build_exp(input int run);
    logic last_pos;
    int par;
    int zeros;
    last_pos = 1'b0;
    par = 0;
    zeros = 0;
    exp_q.delete();
    foreach (in_q[i])
    begin
      if (|in_q[i])
      begin
        last_pos = ~last_pos;
        exp_q.push_back(last_pos ? MARK_P : MARK_N);
        par++;
        zeros = 0;
      end
      else
      begin
        exp_q.push_back(SYM_SPACE);
        zeros++;
        if (run != 0 && zeros == run)
        begin
          if (par % 2 == 0)
          begin
            last_pos = ~last_pos;
            exp_q[exp_q.size() - run] = last_pos ? MARK_P : MARK_N;
          end
          exp_q[exp_q.size() - 1] = last_pos ? MARK_P : MARK_N;
          par = 0;
          zeros = 0;
        end
      end
    end
  endtask : build_exp

  task automatic run_stream(input int run);
    int n;
    n = in_q.size();
    build_exp(run);
    foreach (in_q[i]) i_framer.send(in_q[i].pos, in_q[i].neg);
    repeat (4) i_framer.send(1'b1, 1'b0);
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    check(got_q.size() == n, "symbol count");
    foreach (exp_q[i]) check(got_q[i] === exp_q[i], "line symbol");
    $display("test stream done, run %0d", run);
  endtask : run_stream

  initial
  begin
    rows = '{9'h027, 9'h01c, 9'h197, 9'h16c, 9'h182, 9'h022, 9'h00d, 9'h135};
    repeat (3) @(negedge clk_i);
    check(line_valid_o === 1'b0 && sample_ready_o === 1'b1, "reset values");
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge clk_i);
      host_mode_i <= rows[i].host;
      ctrl_rail_format_i <= rows[i].crf;
      ctrl_build_out_i <= rows[i].cbo;
      rail_format_select_i <= rows[i].prf;
      build_out_select_i <= rows[i].pbo;
      line_mode_i <= rows[i].mode;
      repeat (6) @(negedge clk_i);
      check(single_rail_o === rows[i].sr && decoder_enable_o === rows[i].sr, "format");
      check(build_out_en_o === rows[i].bo, "build-out");
    end
    $display("test config done");
    setup(1'b1, LINE_E3);
    load(32'h80610, 32'h0, 20);
    run_stream(4);
    for (int k = 0; k < 2; k++)
    begin
      setup(1'b1, k == 0 ? LINE_DS3 : LINE_STS1);
      load(32'h08c1, 32'h0, 15);
      run_stream(3);
    end
    setup(1'b0, LINE_DS3);
    load(32'h601, 32'h106, 11);
    run_stream(0);
    // stalled line: the buffer must fill and then refuse samples
    setup(1'b1, LINE_DS3);
    line_ready_i <= 1'b0;
    repeat (16) i_framer.send(1'b1, 1'b0);
    @(negedge clk_i);
    check(ovr_seen && full_seen && line_valid_o === 1'b1, "stall overflow");
    $display("test stall done");
    report_and_stop();
  end
endmodule : tb
